// ---- core/smsp_pkg.sv ----
package smsp_pkg;
  localparam logic [7:0] SMSP_CTRL_OFF  = 8'h00;
  localparam logic [7:0] SMSP_STAT_OFF  = 8'h04;
  localparam logic [7:0] SMSP_IFLAG_OFF = 8'h08;
  localparam logic [7:0] SMSP_TXB_OFF   = 8'h0c;
  localparam logic [7:0] SMSP_RXB_OFF   = 8'h10;
  // control field positions
  localparam int SMSP_C_SCS  = 3;
  localparam int SMSP_C_SE   = 4;
  localparam int SMSP_C_CES  = 5;
  localparam int SMSP_C_PEN  = 6;
  localparam int SMSP_C_SDOD = 7;
  // status and flag positions
  localparam int SMSP_S_RXF  = 0;
  localparam int SMSP_S_RXS  = 1;
  localparam int SMSP_S_TXE  = 5;
  localparam int SMSP_S_TXS  = 6;
  localparam int SMSP_I_RXI  = 2;
  localparam int SMSP_I_TXI  = 7;
  localparam logic [2:0] SMSP_BITS_LAST = 3'h7;
  localparam logic [7:0] SMSP_BYTE_RST  = 8'h00;
  localparam int SMSP_PART_HALF_DEF = 8;
  localparam int SMSP_PART_HALF_MIN = 6;
  typedef enum logic [2:0] {
    SMSP_M_DIV2  = 3'h0,
    SMSP_M_DIV4  = 3'h1,
    SMSP_M_DIV8  = 3'h2,
    SMSP_M_DIV16 = 3'h3,
    SMSP_M_DIV32 = 3'h4,
    SMSP_M_SLVSS = 3'h5,
    SMSP_M_SLV   = 3'h6,
    SMSP_M_TMR   = 3'h7
  } smsp_mode_t;
  typedef enum logic [1:0] {
    SMSP_IDLE = 2'b00,
    SMSP_RUN  = 2'b01,
    SMSP_LAST = 2'b11
  } smsp_state_t;
endpackage

// ---- core/smsp_link.sv ----
`timescale 1ns/100ps
interface smsp_link;
  logic dev_sck_o;
  logic dev_sck_oe_n;
  logic part_sck_o;
  logic part_sck_oe_n;
  logic sck;
  logic dev_sdo;
  logic dev_sdo_oe_n;
  logic part_sdo;
  logic part_sdo_oe_n;
  logic dev_sdi;
  logic part_sdi;
  logic slave_select_pin;
  // wire resolution; undriven lines pull high
  assign sck = !dev_sck_oe_n ? dev_sck_o :
               (!part_sck_oe_n ? part_sck_o : 1'b1);
  assign dev_sdi  = part_sdo_oe_n ? 1'b1 : part_sdo;
  assign part_sdi = dev_sdo_oe_n ? 1'b1 : dev_sdo;
  modport dev (output dev_sck_o, dev_sck_oe_n, dev_sdo, dev_sdo_oe_n,
               input sck, dev_sdi, slave_select_pin);
  modport part (output part_sck_o, part_sck_oe_n, part_sdo,
                part_sdo_oe_n, slave_select_pin, input sck, part_sdi);
endinterface

// ---- core/smsp_partner.sv ----
`timescale 1ns/100ps
module smsp_partner
  import smsp_pkg::*;
#(
  parameter int HALF_DIV = SMSP_PART_HALF_DEF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  smsp_link.part          link,
  input  wire logic       is_master,
  input  wire logic       ces,
  input  wire logic       start,
  input  wire logic [7:0] tx_data,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            busy
);
  initial begin
    if (HALF_DIV < SMSP_PART_HALF_MIN || HALF_DIV > 255)
      $error("HALF_DIV out of range");
  end
  localparam logic [7:0] HLIM = 8'(HALF_DIV - 1);

  smsp_state_t st;
  logic [7:0]  sr;
  logic [2:0]  cnt;
  logic        bit_in;
  logic        phase;
  logic [7:0]  div;
  logic [1:0]  s1;
  logic [1:0]  s2;
  logic        sck_prev;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        smp_ev;
  logic        shf_ev;

  // sck and sdi from the device pass two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      sck_prev <= 1'b1;
    end else begin
      s1 <= {link.sck, link.part_sdi};
      s2 <= s1;
      sck_prev <= s2[1];
    end
  end

  assign tick = (div == HLIM);
  assign rise = s2[1] & ~sck_prev;
  assign fall = ~s2[1] & sck_prev;
  assign smp_ev = is_master ? (tick & ~phase) : (ces ? rise : fall);
  assign shf_ev = is_master ? (tick & phase) : (ces ? fall : rise);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div <= 8'h00;
    else if (st == SMSP_IDLE || tick)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SMSP_IDLE;
      sr <= SMSP_BYTE_RST;
      cnt <= 3'h0;
      bit_in <= 1'b0;
      phase <= 1'b0;
      rx_data <= SMSP_BYTE_RST;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (st != SMSP_IDLE && is_master && tick)
        phase <= ~phase;
      unique case (st)
        SMSP_IDLE: begin
          if (start) begin
            sr <= tx_data;
            cnt <= 3'h0;
            phase <= 1'b0;
            st <= SMSP_RUN;
          end
        end
        SMSP_RUN: begin
          if (smp_ev) begin
            bit_in <= s2[0];
            cnt <= cnt + 3'h1;
            if (cnt == SMSP_BITS_LAST) begin
              rx_data <= {sr[6:0], s2[0]};
              rx_valid <= 1'b1;
              st <= SMSP_LAST;
            end
          end else if (shf_ev) begin
            sr <= {sr[6:0], bit_in};
          end
        end
        SMSP_LAST: begin
          if (shf_ev || !is_master)
            st <= SMSP_IDLE;
        end
      endcase
    end
  end

  assign busy = (st != SMSP_IDLE);
  assign link.part_sck_o = phase ^ ~ces;
  assign link.part_sck_oe_n = ~is_master;
  assign link.part_sdo = sr[7];
  assign link.part_sdo_oe_n = 1'b0;
  assign link.slave_select_pin = ~(is_master & busy);
endmodule // smsp_partner

// ---- core/smsp_port.sv ----
// Operation
// - eight bits, full duplex, msb first
// - start copies tx buffer, sets tx flags
// - eighth bit moves byte, sets rx flags
// - tx empty clears by zero or tx write
// - rx full clears by zero or read
// - master drives sck, slave follows it
// - mode codes pick master clock divider
// - codes 101, 110 are slave modes
// - edge bit one: out fall, in rise
// - software enables port, then sets mode
// - master, select zero: shift enable starts
// - shift enable holds, hardware clears at end
// - software resets shift enable per byte
// - master, select one: tx write starts
// - select one: continue only on new byte; a slave here reloads on the next clock without one
// - write next byte before current ends
// - read rx before next byte completes
// - only software clears the flags
// - receive only: data out may be off
// - select high floats data out at once; here only after the two select flops
// - bit counter zero on select or disable
// - slave re-arms before next clock pulse
`timescale 1ns/100ps
module smsp_port
  import smsp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer_tick,
  smsp_link.dev                  link
);
  initial begin
    if (ADDR_W < 8)
      $error("ADDR_W below 8");
  end

  function automatic logic is_slave(input logic [2:0] m);
    return m == SMSP_M_SLVSS || m == SMSP_M_SLV;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  function automatic logic flag(input logic v, input logic set,
                                input logic wr, input logic b);
    return set | (v & ~(wr & ~b));
  endfunction

  smsp_mode_t  mode;
  smsp_state_t st;
  logic        scs;
  logic        se;
  logic        ces;
  logic        pen;
  logic        sdo_off;
  logic [7:0]  transmit_buffer;
  logic [7:0]  receive_buffer;
  logic [7:0]  serial_shift_reg;
  logic [2:0]  cnt;
  logic        bit_in;
  logic        phase;
  logic        pend;
  logic        tx_buffer_empty;
  logic        tx_status_flag;
  logic        tx_interrupt_flag;
  logic        rx_buffer_full;
  logic        rx_status_flag;
  logic        rx_interrupt_flag;
  logic [4:0]  div;
  logic [2:0]  s1;
  logic [2:0]  s2;
  logic        sck_prev;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_iflag;
  logic        wr_txb;
  logic        rd_rxb;
  logic        slave;
  logic        ss_off;
  logic        abort;
  logic        half_tick;
  logic        rise;
  logic        fall;
  logic        smp_ev;
  logic        shf_ev;
  logic        m_start;
  logic        s_load;
  logic        m_cont;
  logic        ld;
  logic        rx_set;
  logic        done;

  // sck, sdi, select pass two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 3'h7;
      s2 <= 3'h7;
      sck_prev <= 1'b1;
    end else begin
      s1 <= {link.sck, link.dev_sdi, link.slave_select_pin};
      s2 <= s1;
      sck_prev <= s2[2];
    end
  end

  // apb decode
  assign acc = psel & penable;
  assign wr_ctrl = acc & pwrite & hit(paddr, SMSP_CTRL_OFF);
  assign wr_stat = acc & pwrite & hit(paddr, SMSP_STAT_OFF);
  assign wr_iflag = acc & pwrite & hit(paddr, SMSP_IFLAG_OFF);
  assign wr_txb = acc & pwrite & hit(paddr, SMSP_TXB_OFF);
  assign rd_rxb = acc & ~pwrite & hit(paddr, SMSP_RXB_OFF);
  assign pready = 1'b1;
  assign pslverr = acc & ~(hit(paddr, SMSP_CTRL_OFF)
                   | hit(paddr, SMSP_STAT_OFF) | hit(paddr, SMSP_IFLAG_OFF)
                   | hit(paddr, SMSP_TXB_OFF) | hit(paddr, SMSP_RXB_OFF));

  // read data caught in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (hit(paddr, SMSP_CTRL_OFF))
        prdata[7:0] <= {sdo_off, pen, ces, se, scs, mode};
      if (hit(paddr, SMSP_STAT_OFF)) begin
        prdata[SMSP_S_RXF] <= rx_buffer_full;
        prdata[SMSP_S_RXS] <= rx_status_flag;
        prdata[SMSP_S_TXE] <= tx_buffer_empty;
        prdata[SMSP_S_TXS] <= tx_status_flag;
      end
      if (hit(paddr, SMSP_IFLAG_OFF)) begin
        prdata[SMSP_I_RXI] <= rx_interrupt_flag;
        prdata[SMSP_I_TXI] <= tx_interrupt_flag;
      end
      if (hit(paddr, SMSP_TXB_OFF))
        prdata[7:0] <= transmit_buffer;
      if (hit(paddr, SMSP_RXB_OFF))
        prdata[7:0] <= receive_buffer;
    end
  end

  assign slave = is_slave(mode);
  assign ss_off = (mode == SMSP_M_SLVSS) & s2[0];
  assign abort = ~pen | ss_off;

  // master clock divider
  assign half_tick = (mode == SMSP_M_TMR) ? timer_tick
                     : (div == 5'((5'h1 << mode) - 5'h1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div <= 5'h0;
    else if (st == SMSP_IDLE || half_tick)
      div <= 5'h0;
    else
      div <= div + 5'h1;
  end

  // sample on leading edge, shift on trailing edge
  assign rise = s2[2] & ~sck_prev;
  assign fall = ~s2[2] & sck_prev;
  assign smp_ev = slave ? (ces ? rise : fall)
                  : (half_tick & ~phase);
  assign shf_ev = slave ? (ces ? fall : rise)
                  : (half_tick & phase);

  assign m_start = (st == SMSP_IDLE) & pen & ~slave
                   & (scs ? pend : se);
  assign s_load = (st == SMSP_IDLE) & pen & slave & ~ss_off & smp_ev
                  & (scs | se);
  assign m_cont = (st == SMSP_LAST) & ~slave & scs & pend & shf_ev;
  assign ld = ~abort & (m_start | s_load | m_cont);
  assign rx_set = ~abort & (st == SMSP_RUN) & smp_ev
                  & (cnt == SMSP_BITS_LAST);
  assign done = ~abort & (st == SMSP_LAST) & shf_ev & ~m_cont;

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= SMSP_M_DIV2;
      scs <= 1'b0;
      ces <= 1'b0;
      pen <= 1'b0;
      sdo_off <= 1'b0;
    end else if (wr_ctrl) begin
      mode <= smsp_mode_t'(pwdata[2:0]);
      scs <= pwdata[SMSP_C_SCS];
      ces <= pwdata[SMSP_C_CES];
      pen <= pwdata[SMSP_C_PEN];
      sdo_off <= pwdata[SMSP_C_SDOD];
    end
  end

  // shift enable: software sets, hardware clears at byte end when select is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      se <= 1'b0;
    else if (wr_ctrl)
      se <= pwdata[SMSP_C_SE];
    else if (st == SMSP_LAST && (shf_ev || abort) && !scs)
      se <= 1'b0;
  end

  // transmit buffer and pending-write mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer <= SMSP_BYTE_RST;
      pend <= 1'b0;
    end else begin
      if (wr_txb)
        transmit_buffer <= pwdata[7:0];
      if (wr_txb && scs)
        pend <= 1'b1;
      else if (ld || !pen)
        pend <= 1'b0;
    end
  end

  // shift engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SMSP_IDLE;
      serial_shift_reg <= SMSP_BYTE_RST;
      receive_buffer <= SMSP_BYTE_RST;
      cnt <= 3'h0;
      bit_in <= 1'b0;
      phase <= 1'b0;
    end else if (abort) begin
      st <= SMSP_IDLE;
      cnt <= 3'h0;
      phase <= 1'b0;
    end else begin
      if (st != SMSP_IDLE && !slave && half_tick)
        phase <= ~phase;
      if (ld)
        serial_shift_reg <= transmit_buffer;
      unique case (st)
        SMSP_IDLE: begin
          if (m_start) begin
            cnt <= 3'h0;
            phase <= 1'b0;
            st <= SMSP_RUN;
          end else if (s_load) begin
            bit_in <= s2[1];
            cnt <= 3'h1;
            st <= SMSP_RUN;
          end
        end
        SMSP_RUN: begin
          if (smp_ev) begin
            bit_in <= s2[1];
            cnt <= cnt + 3'h1;
            if (rx_set) begin
              receive_buffer <= {serial_shift_reg[6:0], s2[1]};
              st <= SMSP_LAST;
            end
          end else if (shf_ev) begin
            serial_shift_reg <= {serial_shift_reg[6:0], bit_in};
          end
        end
        SMSP_LAST: begin
          if (m_cont) begin
            cnt <= 3'h0;
            st <= SMSP_RUN;
          end else if (done) begin
            st <= SMSP_IDLE;
          end
        end
      endcase
    end
  end

  // sticky flags: set wins, software write of zero clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty <= 1'b0;
      tx_status_flag <= 1'b0;
      tx_interrupt_flag <= 1'b0;
      rx_buffer_full <= 1'b0;
      rx_status_flag <= 1'b0;
      rx_interrupt_flag <= 1'b0;
    end else begin
      tx_buffer_empty <= flag(tx_buffer_empty & ~wr_txb, ld,
                              wr_stat, pwdata[SMSP_S_TXE]);
      tx_status_flag <= flag(tx_status_flag, ld,
                             wr_stat, pwdata[SMSP_S_TXS]);
      tx_interrupt_flag <= flag(tx_interrupt_flag, ld,
                                wr_iflag, pwdata[SMSP_I_TXI]);
      rx_buffer_full <= flag(rx_buffer_full & ~rd_rxb, rx_set,
                             wr_stat, pwdata[SMSP_S_RXF]);
      rx_status_flag <= flag(rx_status_flag, rx_set,
                             wr_stat, pwdata[SMSP_S_RXS]);
      rx_interrupt_flag <= flag(rx_interrupt_flag, rx_set,
                                wr_iflag, pwdata[SMSP_I_RXI]);
    end
  end

  // pins
  assign link.dev_sck_o = phase ^ ~ces;
  assign link.dev_sck_oe_n = ~(pen & ~slave);
  assign link.dev_sdo = (st == SMSP_IDLE) ? transmit_buffer[7]
                        : serial_shift_reg[7];
  assign link.dev_sdo_oe_n = ~(pen & ~sdo_off & ~ss_off);
endmodule // smsp_port

// ---- verification/smsp_props.sv ----
`timescale 1ns/100ps
module smsp_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic slave_select_pin,
  input wire logic dev_sck_oe_n,
  input wire logic part_sck_oe_n,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe_n,
  input wire logic part_sdo_oe_n
);
  logic [3:0] nbits;
  logic       sck_q;
  logic       ssb_q;

  // rising sck edges within one select frame, end edge included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      ssb_q <= 1'b1;
      nbits <= 4'h0;
    end else begin
      sck_q <= sck;
      ssb_q <= slave_select_pin;
      if (slave_select_pin && ssb_q) begin
        nbits <= 4'h0;
      end else if (sck && !sck_q && !ssb_q) begin
        nbits <= nbits + 4'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RST_RELEASE: assert property (
    $rose(presetn) |-> (dev_sck_oe_n && dev_sdo_oe_n) [*2])
    else $error("pins driven right after reset");
  AST_SLAVE_SCK_IN: assert property (!slave_select_pin |-> dev_sck_oe_n)
    else $error("device drives sck in a far-end frame");
  AST_FAR_SCK_OUT: assert property (!slave_select_pin |-> !part_sck_oe_n)
    else $error("far end selects without driving sck");
  AST_NO_CLASH: assert property (!(!dev_sck_oe_n && !part_sck_oe_n))
    else $error("two drivers on sck");
  AST_FAR_SDO_ON: assert property (!part_sdo_oe_n)
    else $error("far end data out released");
  AST_BITS_MAX: assert property (nbits <= 4'h8)
    else $error("more than eight clocks in a frame");
  AST_BITS_END: assert property ($rose(slave_select_pin) |=> nbits == 4'h8)
    else $error("frame ended without eight clocks");
  AST_SDO_AT_EDGE: assert property (
    !slave_select_pin && $changed(sck) |-> $stable(dev_sdo) ##1 $stable(dev_sdo))
    else $error("device data out moved at an sck edge");

  cover property ($rose(slave_select_pin) && nbits == 4'h8);
  cover property ($fell(dev_sck_oe_n));
  cover property ($rose(dev_sdo_oe_n) && slave_select_pin);
endmodule // smsp_props

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  import smsp_pkg::*;
  localparam logic [31:0] FL_RXF = 32'h1 << SMSP_S_RXF;
  localparam logic [31:0] FL_TX = (32'h1 << SMSP_S_TXE) | (32'h1 << SMSP_S_TXS);
  localparam logic [31:0] FL_ALL = FL_TX | FL_RXF | (32'h1 << SMSP_S_RXS);
  localparam logic [31:0] FL_IRQ = (32'h1 << SMSP_I_RXI) | (32'h1 << SMSP_I_TXI);
  localparam int TMR_PER = 5;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, timer_tick, perr;
  logic [7:0]  paddr, ptx, prx_data, prx_last;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, is_master, pces, pstart, prx_valid, pbusy;
  logic        sck_q = 1'b1;
  int          err_total = 0, total_checks = 0, rises = 0, prx_cnt = 0, tk = 0;
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  smsp_link link ();
  smsp_port u_smsp_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .link(link));
  smsp_partner u_smsp_partner (.pclk(pclk), .presetn(presetn), .link(link),
    .is_master(is_master), .ces(pces), .start(pstart), .tx_data(ptx),
    .rx_data(prx_data), .rx_valid(prx_valid), .busy(pbusy));
  smsp_props u_smsp_props (.pclk(pclk), .presetn(presetn), .sck(link.sck),
    .slave_select_pin(link.slave_select_pin), .dev_sck_oe_n(link.dev_sck_oe_n),
    .part_sck_oe_n(link.part_sck_oe_n), .dev_sdo(link.dev_sdo),
    .dev_sdo_oe_n(link.dev_sdo_oe_n), .part_sdo_oe_n(link.part_sdo_oe_n));

  always #5 pclk = ~pclk;

  // sck edge count, far-end receive capture, timer pulse
  always @(posedge pclk) begin
    sck_q <= link.sck;
    if (link.sck && !sck_q) rises <= rises + 1;
    if (prx_valid) begin
      prx_cnt <= prx_cnt + 1;
      prx_last <= prx_data;
    end
    tk <= (tk + 1) % TMR_PER;
    timer_tick <= (tk == 0);
  end

  task automatic tally_and_finish(input logic hung);
    if (hung) err_total++;
    $display("comparisons %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic guard(ref int n);
    n++;
    if (n > 3000) tally_and_finish(1'b1);
    @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) guard(n);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    `CHK(q, v)
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, q);
      guard(n);
    end while (q[b] !== 1'b1);
  endtask

  task automatic clr_flags();
    logic [31:0] q;
    wr(SMSP_STAT_OFF, 32'h0);
    wr(SMSP_IFLAG_OFF, 32'h0);
    apb(1'b0, SMSP_RXB_OFF, 32'h0, q);
  endtask

  task automatic pgo(input logic [7:0] d);
    ptx <= d;
    pstart <= 1'b1;
    @(posedge pclk);
    pstart <= 1'b0;
  endtask

  function automatic logic [31:0] cw(logic [2:0] m, logic s, e, c);
    return {25'h0, 1'b1, c, e, s, m};
  endfunction

  task automatic t_reset();
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    rd_chk(8'h14, 32'h0);
    `CHK(perr, 1'b1)
    $display("test reset done");
  endtask

  task automatic t_master(input logic [2:0] m, input logic c,
                          input logic [7:0] dt, pt);
    logic [31:0] q;
    logic        s;
    logic        dchk;
    int          n, h, b;
    dchk = (m >= 3'h3) && (m != SMSP_M_TMR);
    is_master <= 1'b0;
    pces <= c;
    wr(SMSP_TXB_OFF, {24'h0, dt});
    wr(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b0, c));
    `CHK(link.sck, ~c)
    // let the far end see the idle-level change before it is armed
    repeat (4) @(posedge pclk);
    b = prx_cnt;
    if (dchk) pgo(pt);
    wr(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b1, c));
    n = 0;
    h = 0;
    s = link.sck;
    while (link.sck === s) guard(n);
    s = link.sck;
    while (link.sck === s) begin
      guard(n);
      h++;
    end
    `CHK(h, (m == SMSP_M_TMR) ? TMR_PER : (1 << m))
    poll(SMSP_STAT_OFF, SMSP_S_RXF);
    rd_chk(SMSP_STAT_OFF, FL_ALL);
    rd_chk(SMSP_IFLAG_OFF, FL_IRQ);
    // shift enable drops at the last trailing edge, half a period on
    repeat (1 << m) @(posedge pclk);
    rd_chk(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b0, c));
    if (dchk) begin
      rd_chk(SMSP_RXB_OFF, {24'h0, pt});
      while (prx_cnt == b) guard(n);
      `CHK(prx_last, dt)
    end else begin
      apb(1'b0, SMSP_RXB_OFF, 32'h0, q);
    end
    rd_chk(SMSP_STAT_OFF, FL_ALL & ~FL_RXF);
    clr_flags();
    rd_chk(SMSP_STAT_OFF, 32'h0);
    rd_chk(SMSP_IFLAG_OFF, 32'h0);
    $display("test master mode %0d done", m);
  endtask

  task automatic t_stream();
    logic [31:0] q;
    int n, b;
    n = 0;
    b = rises;
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b1, 1'b0, 1'b1));
    wr(SMSP_TXB_OFF, 32'h5a);
    poll(SMSP_STAT_OFF, SMSP_S_TXE);
    wr(SMSP_TXB_OFF, 32'h3c);
    apb(1'b0, SMSP_STAT_OFF, 32'h0, q);
    `CHK(q[SMSP_S_TXE], 1'b0)
    while (rises - b < 16) guard(n);
    repeat (40) @(posedge pclk);
    `CHK(rises - b, 16)
    clr_flags();
    $display("test stream done");
  endtask

  task automatic t_abort();
    int n, b;
    n = 0;
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b0, 1'b1));
    b = rises;
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b1, 1'b1));
    while (rises - b < 3) guard(n);
    wr(SMSP_CTRL_OFF, 32'h0);
    rd_chk(SMSP_STAT_OFF, FL_TX);
    clr_flags();
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b0, 1'b1));
    b = rises;
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b1, 1'b1));
    poll(SMSP_STAT_OFF, SMSP_S_RXF);
    `CHK(rises - b, 8)
    clr_flags();
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b0, 1'b1) | (32'h1 << SMSP_C_SDOD));
    `CHK(link.dev_sdo_oe_n, 1'b1)
    wr(SMSP_CTRL_OFF, cw(3'h3, 1'b0, 1'b0, 1'b1));
    `CHK(link.dev_sdo_oe_n, 1'b0)
    $display("test abort done");
  endtask

  task automatic t_slave(input logic [2:0] m, input logic c,
                         input logic [7:0] dt, pt);
    int n, b;
    n = 0;
    wr(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b0, c));
    is_master <= 1'b1;
    pces <= c;
    wr(SMSP_TXB_OFF, {24'h0, dt});
    wr(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b1, c));
    b = prx_cnt;
    pgo(pt);
    while (prx_cnt == b) guard(n);
    `CHK(prx_last, dt)
    poll(SMSP_STAT_OFF, SMSP_S_RXF);
    rd_chk(SMSP_RXB_OFF, {24'h0, pt});
    rd_chk(SMSP_CTRL_OFF, cw(m, 1'b0, 1'b0, c));
    if (m == SMSP_M_SLVSS) `CHK(link.dev_sdo_oe_n, 1'b1)
    clr_flags();
    b = prx_cnt;
    pgo(8'h0f);
    while (prx_cnt == b) guard(n);
    rd_chk(SMSP_IFLAG_OFF, 32'h0);
    is_master <= 1'b0;
    $display("test slave mode %0d done", m);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_tick = 1'b0;
    is_master = 1'b0;
    pces = 1'b0;
    pstart = 1'b0;
    ptx = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    for (int m = 0; m < 5; m++) t_master(3'(m), 1'(m), 8'(8'hc3 + m), 8'h5a);
    t_master(SMSP_M_TMR, 1'b1, 8'h3e, 8'h5a);
    t_stream();
    t_abort();
    t_slave(SMSP_M_SLVSS, 1'b1, 8'h96, 8'h1e);
    t_slave(SMSP_M_SLV, 1'b0, 8'h71, 8'he8);
    tally_and_finish(1'b0);
  end
endmodule // tb_top
